// ### hdl/dhi_device_end.sv
// Display interface end: strap select, byte steering and output buffer.
`timescale 1ns/100ps
`default_nettype none

module dhi_device_end import dhi_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	// Link pins
	dhi_link_if.device      link,
	// Read-back byte for parallel reads
	input  wire logic [7:0] rd_byte_i,
	// Received byte stream
	input  wire logic       out_ready_i,
	output logic            out_valid_o,
	output logic [7:0]      out_byte_o,
	output logic            out_is_data_o,
	// Status
	output logic            overrun_o,
	output logic            init_busy_o,
	output logic [1:0]      mode_o
);

	typedef struct packed {
		logic [SY_W-1:0]   sy1;
		logic [SY_W-1:0]   sy2;
		logic [SY_W-1:0]   sy3;
		logic [1:0]        mode;
		logic [7:0]        init_cnt;
		logic              busy;
		dhi_i2c_state_type ist;
		logic [7:0]        sh;
		logic [3:0]        bits;
		logic              addr_ph;
		logic              ctrl_ph;
		logic              i2c_dc;
		logic [7:0]        bus_out;
		logic [7:0]        bus_oe;
		logic              hv;
		logic [8:0]        hd;
		logic              tv;
		logic [8:0]        td;
		logic              ovr;
	} dhi_dev_type;

	dhi_dev_type s_r;
	dhi_dev_type s_nxt;

	logic [7:0] bus;
	logic       por_n;
	logic       sel_n;
	logic       dc;
	logic       en;
	logic       en_prev;
	logic       rw;
	logic       rw_prev;
	logic       sck;
	logic       sck_prev;
	logic       sda;
	logic       sda_prev;
	logic       push;
	logic [8:0] push_d;
	logic [7:0] shin;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Pins come from the host's clock; only the second and third
		// stages are decoded so that no logic reads a metastable flop.
		s_nxt.sy1 = {link.rw_wr, link.en_rd, link.data_cmd_sel,
			link.host_sel_n, link.power_on_init_n,
			link.iface_strap_b, link.iface_strap_a,
			link.host_bus_lines};
		s_nxt.sy2 = s_r.sy1;
		s_nxt.sy3 = s_r.sy2;
		s_nxt.ovr = 1'b0;
		bus      = s_r.sy2[7:0];
		por_n    = s_r.sy2[SY_POR_N];
		sel_n    = s_r.sy2[SY_SEL_N];
		dc       = s_r.sy2[SY_DC];
		en       = s_r.sy2[SY_EN_RD];
		en_prev  = s_r.sy3[SY_EN_RD];
		rw       = s_r.sy2[SY_RW_WR];
		rw_prev  = s_r.sy3[SY_RW_WR];
		sck      = bus[SCK_LINE];
		sck_prev = s_r.sy3[SCK_LINE];
		sda      = bus[SDI_LINE];
		sda_prev = s_r.sy3[SDI_LINE];
		shin     = {s_r.sh[6:0], sda};
		push     = 1'b0;
		push_d   = 9'h000;

		// Output buffer drain.
		if (s_r.hv && out_ready_i) begin
			s_nxt.hv = s_r.tv;
			s_nxt.hd = s_r.td;
			s_nxt.tv = 1'b0;
		end

		if (!por_n || s_r.busy) begin
			// Straps are caught while initialisation runs.
			s_nxt.mode    = {s_r.sy2[SY_STRAP_A], s_r.sy2[SY_STRAP_B]};
			s_nxt.ist     = I2C_IDLE;
			s_nxt.bits    = 4'h0;
			s_nxt.bus_oe  = 8'h00;
			s_nxt.bus_out = 8'h00;
			if (!por_n) begin
				s_nxt.busy     = 1'b1;
				s_nxt.init_cnt = INIT_CYC;
				s_nxt.hv       = 1'b0;
				s_nxt.tv       = 1'b0;
			end else if (s_r.init_cnt == 8'h00) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.init_cnt = s_r.init_cnt - 8'h01;
			end
		end else if (sel_n) begin
			s_nxt.ist     = I2C_IDLE;
			s_nxt.bits    = 4'h0;
			s_nxt.bus_oe  = 8'h00;
			s_nxt.bus_out = 8'h00;
		end else if (is_parallel(s_r.mode)) begin
			s_nxt.bus_out = rd_byte_i;
			if (s_r.mode == MODE_ENABLE_STROBE) begin
				s_nxt.bus_oe = (en && rw) ? 8'hff : 8'h00;
				if (en_prev && !en && !rw) begin
					push   = 1'b1;
					push_d = {dc, bus};
				end
			end else begin
				s_nxt.bus_oe = !en ? 8'hff : 8'h00;
				if (!rw_prev && rw) begin
					push   = 1'b1;
					push_d = {dc, bus};
				end
			end
		end else if (s_r.mode == MODE_SPI) begin
			s_nxt.bus_oe = 8'h00;
			if (sck && !sck_prev) begin
				s_nxt.sh   = shin;
				s_nxt.bits = s_r.bits + 4'h1;
				if (s_r.bits == 4'h7) begin
					s_nxt.bits = 4'h0;
					push       = 1'b1;
					push_d     = {dc, shin};
				end
			end
		end else begin
			s_nxt.bus_out = 8'h00;
			if (sck && sck_prev && sda_prev && !sda) begin
				s_nxt.ist     = I2C_RECV;
				s_nxt.bits    = 4'h0;
				s_nxt.addr_ph = 1'b1;
				s_nxt.bus_oe  = 8'h00;
			end else if (sck && sck_prev && !sda_prev && sda) begin
				s_nxt.ist    = I2C_IDLE;
				s_nxt.bus_oe = 8'h00;
			end else begin
				case (s_r.ist)
					I2C_RECV: begin
						if (sck && !sck_prev && s_r.bits != 4'h8) begin
							s_nxt.sh   = shin;
							s_nxt.bits = s_r.bits + 4'h1;
						end else if (!sck && sck_prev && s_r.bits == 4'h8) begin
							s_nxt.bits = 4'h0;
							s_nxt.ist  = I2C_ACK;
							if (s_r.addr_ph) begin
								s_nxt.addr_ph = 1'b0;
								s_nxt.ctrl_ph = 1'b1;
								if (s_r.sh != {I2C_ADDR_HI, dc, 1'b0}) begin
									s_nxt.ist = I2C_SKIP;
								end
							end else if (s_r.ctrl_ph) begin
								s_nxt.ctrl_ph = 1'b0;
								s_nxt.i2c_dc  = s_r.sh[CTRL_DC_BIT];
							end else if (!s_r.tv) begin
								push   = 1'b1;
								push_d = {s_r.i2c_dc, s_r.sh};
							end else begin
								// A full buffer answers with a missing
								// acknowledge, so the host sees the stall.
								s_nxt.ist = I2C_SKIP;
							end
							if (s_nxt.ist == I2C_ACK) begin
								s_nxt.bus_oe[SDA_OUT_LINE] = 1'b1;
							end
						end
					end
					I2C_ACK: begin
						if (!sck && sck_prev) begin
							s_nxt.bus_oe = 8'h00;
							s_nxt.ist    = I2C_RECV;
						end
					end
					I2C_SKIP: s_nxt.bus_oe = 8'h00;
					I2C_IDLE: s_nxt.bus_oe = 8'h00;
					default:  s_nxt.ist = I2C_IDLE;
				endcase
			end
		end

		// Output buffer fill; the parallel and SPI links cannot be
		// stalled, so a third byte is dropped and flagged.
		if (push) begin
			if (!s_nxt.hv) begin
				s_nxt.hv = 1'b1;
				s_nxt.hd = push_d;
			end else if (!s_nxt.tv) begin
				s_nxt.tv = 1'b1;
				s_nxt.td = push_d;
			end else begin
				s_nxt.ovr = 1'b1;
			end
		end

		if (reset_i) begin
			s_nxt          = '0;
			s_nxt.busy     = 1'b1;
			s_nxt.init_cnt = INIT_CYC;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		s_r <= s_nxt;
	end

	assign out_valid_o      = s_r.hv;
	assign out_byte_o       = s_r.hd[7:0];
	assign out_is_data_o    = s_r.hd[8];
	assign overrun_o        = s_r.ovr;
	assign init_busy_o      = s_r.busy;
	assign mode_o           = s_r.mode;
	assign link.dev_bus_out = s_r.bus_out;
	assign link.dev_bus_oe  = s_r.bus_oe;

endmodule // dhi_device_end

`default_nettype wire

// ### include/dhi_pkg.sv
// Shared constants and types for the display host interface select link.
`default_nettype none

package dhi_pkg;

	// ---------------------------------------------------------------
	// Interface select strap patterns, {iface_strap_a, iface_strap_b}
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_I2C           = 2'b10;
	localparam logic [1:0] MODE_SPI           = 2'b00;
	localparam logic [1:0] MODE_ENABLE_STROBE = 2'b01;
	localparam logic [1:0] MODE_SEP_STROBE    = 2'b11;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int         CLK_NS         = 100;
	localparam int         LINK_HALF_NS   = 400;
	localparam int         STROBE_NS      = 800;
	localparam int         INIT_NS        = 2000;
	localparam logic [3:0] HALF_CYC       = 4'(LINK_HALF_NS / CLK_NS);
	localparam logic [3:0] STROBE_CYC     = 4'(STROBE_NS / CLK_NS);
	localparam logic [7:0] INIT_CYC       =
		8'((INIT_NS + CLK_NS - 1) / CLK_NS);

	// ---------------------------------------------------------------
	// Host bus line roles in the serial modes
	// ---------------------------------------------------------------
	localparam int         SCK_LINE       = 0;
	localparam int         SDI_LINE       = 1;
	localparam int         SDA_OUT_LINE   = 2;
	localparam logic [7:0] SPI_IDLE_OE    = 8'hfb;
	localparam logic [7:0] I2C_IDLE_OE    = 8'hf9;
	localparam logic [7:0] I2C_IDLE_OUT   = 8'h01;

	// ---------------------------------------------------------------
	// Synchroniser vector field positions
	// ---------------------------------------------------------------
	localparam int         SY_STRAP_A     = 8;
	localparam int         SY_STRAP_B     = 9;
	localparam int         SY_POR_N       = 10;
	localparam int         SY_SEL_N       = 11;
	localparam int         SY_DC          = 12;
	localparam int         SY_EN_RD       = 13;
	localparam int         SY_RW_WR       = 14;
	localparam int         SY_W           = 15;

	// ---------------------------------------------------------------
	// Serial address and control byte
	// ---------------------------------------------------------------
	// Upper address bits are arbitrary.
	localparam logic [5:0] I2C_ADDR_HI    = 6'h2a;
	localparam logic       I2C_HOST_SA0   = 1'h0;
	localparam int         CTRL_DC_BIT    = 6;
	localparam logic [4:0] I2C_FRAME_BITS = 5'h1b;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h08;
	localparam logic [4:0] ACK_SLOT_A     = 5'h13;
	localparam logic [4:0] ACK_SLOT_B     = 5'h0a;
	localparam logic [4:0] ACK_SLOT_C     = 5'h01;

	typedef enum logic [1:0] {
		I2C_IDLE, I2C_RECV, I2C_ACK, I2C_SKIP
	} dhi_i2c_state_type;

	typedef enum logic [3:0] {
		H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_START,
		H_SHIFT_LO, H_SHIFT_HI, H_STOP, H_STOP2
	} dhi_host_state_type;

	function automatic logic is_parallel(input logic [1:0] m);
		return (m == MODE_ENABLE_STROBE) || (m == MODE_SEP_STROBE);
	endfunction

endpackage

`default_nettype wire

// ### include/dhi_link_if.sv
// Pin-level link between the host end and the display interface end.
`timescale 1ns/100ps
`default_nettype none

interface dhi_link_if;
	import dhi_pkg::*;

	logic       iface_strap_a;
	logic       iface_strap_b;
	logic       power_on_init_n;
	logic       host_sel_n;
	logic       data_cmd_sel;
	logic       en_rd;
	logic       rw_wr;
	logic [7:0] host_bus_out;
	logic [7:0] host_bus_oe;
	logic [7:0] dev_bus_out;
	logic [7:0] dev_bus_oe;
	logic [7:0] lvl;
	logic [7:0] host_bus_lines;
	logic       sda_join;

	// Released lines are pulled high; any low driver wins.
	for (genvar i = 0; i < 8; i++) begin : g_line
		assign lvl[i] = (~host_bus_oe[i] | host_bus_out[i]) &
			(~dev_bus_oe[i] | dev_bus_out[i]);
	end

	assign sda_join = lvl[SDA_OUT_LINE] & lvl[SDI_LINE];
	assign host_bus_lines =
		({iface_strap_a, iface_strap_b} == MODE_I2C) ?
		{lvl[7:3], sda_join, sda_join, lvl[0]} : lvl;

	modport host (
		output iface_strap_a, iface_strap_b, power_on_init_n,
		output host_sel_n, data_cmd_sel, en_rd, rw_wr,
		output host_bus_out, host_bus_oe,
		input  host_bus_lines
	);

	modport device (
		input  iface_strap_a, iface_strap_b, power_on_init_n,
		input  host_sel_n, data_cmd_sel, en_rd, rw_wr,
		input  host_bus_lines,
		output dev_bus_out, dev_bus_oe
	);

endinterface

`default_nettype wire

// ### hdl/dhi_host_end.sv
// Host end: drives the selected link from a byte request port.
`timescale 1ns/100ps
`default_nettype none

module dhi_host_end import dhi_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	// Link pins
	dhi_link_if.host        link,
	// Configuration
	input  wire logic [1:0] mode_i,
	input  wire logic       init_req_i,
	// Request
	input  wire logic       req_valid_i,
	input  wire logic       req_read_i,
	input  wire logic       req_is_data_i,
	input  wire logic [7:0] req_byte_i,
	output logic            req_ready_o,
	// Response
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_byte_o,
	output logic            nack_o
);

	typedef struct packed {
		dhi_host_state_type st;
		logic [3:0]         tmr;
		logic [1:0]         mode;
		logic               por_n;
		logic               sel_n;
		logic               dc;
		logic               en_rd;
		logic               rw_wr;
		logic [7:0]         bus_out;
		logic [7:0]         bus_oe;
		logic [7:0]         sy1;
		logic [7:0]         sy2;
		logic               rd;
		logic [26:0]        sh;
		logic [4:0]         bits;
		logic               ready;
		logic               rsp_v;
		logic [7:0]         rsp;
		logic               nack;
	} dhi_host_type;

	dhi_host_type s_r;
	dhi_host_type s_nxt;
	logic         tdone;
	logic         i2c;
	logic [7:0]   ctrl;

	always_comb begin
		s_nxt       = s_r;
		s_nxt.sy1   = link.host_bus_lines;
		s_nxt.sy2   = s_r.sy1;
		s_nxt.rsp_v = 1'b0;
		s_nxt.por_n = !init_req_i;
		tdone       = (s_r.tmr == 4'h0);
		i2c         = (s_r.mode == MODE_I2C);
		ctrl        = 8'h00;
		ctrl[CTRL_DC_BIT] = req_is_data_i;
		if (!tdone) begin
			s_nxt.tmr = s_r.tmr - 4'h1;
		end
		case (s_r.st)
			H_IDLE: begin
				s_nxt.mode  = mode_i;
				s_nxt.ready = 1'b1;
				s_nxt.tmr   = HALF_CYC;
				if (is_parallel(mode_i)) begin
					s_nxt.en_rd  = (mode_i == MODE_SEP_STROBE);
					s_nxt.rw_wr  = (mode_i == MODE_SEP_STROBE);
					s_nxt.bus_oe = 8'h00;
				end else begin
					s_nxt.en_rd   = 1'b0;
					s_nxt.rw_wr   = 1'b0;
					s_nxt.bus_oe  = (mode_i == MODE_I2C) ?
						I2C_IDLE_OE : SPI_IDLE_OE;
					s_nxt.bus_out = (mode_i == MODE_I2C) ?
						I2C_IDLE_OUT : 8'h00;
				end
				// Serial reads are not supported and are consumed.
				if (req_valid_i && s_r.ready && s_r.mode == mode_i &&
					!(req_read_i && !is_parallel(s_r.mode))) begin
					s_nxt.ready = 1'b0;
					s_nxt.nack  = 1'b0;
					s_nxt.sel_n = 1'b0;
					s_nxt.rd    = req_read_i;
					s_nxt.dc    = i2c ? I2C_HOST_SA0 : req_is_data_i;
					if (is_parallel(s_r.mode)) begin
						s_nxt.bus_out = req_byte_i;
						s_nxt.bus_oe  = req_read_i ? 8'h00 : 8'hff;
						if (s_r.mode == MODE_ENABLE_STROBE) begin
							s_nxt.rw_wr = req_read_i;
						end
						s_nxt.st = H_SETUP;
					end else if (i2c) begin
						s_nxt.sh = {I2C_ADDR_HI, I2C_HOST_SA0, 1'b0, 1'b1,
							ctrl, 1'b1, req_byte_i, 1'b1};
						s_nxt.bits = I2C_FRAME_BITS;
						s_nxt.bus_oe[SDI_LINE] = 1'b1;
						s_nxt.st = H_START;
					end else begin
						s_nxt.sh = {req_byte_i, 19'h00000};
						s_nxt.bits = SPI_FRAME_BITS;
						s_nxt.bus_out[SCK_LINE] = 1'b0;
						s_nxt.bus_out[SDI_LINE] = req_byte_i[7];
						s_nxt.st = H_SHIFT_LO;
					end
				end
			end
			H_SETUP: begin
				if (tdone) begin
					s_nxt.tmr = STROBE_CYC;
					s_nxt.st  = H_STROBE;
					if (s_r.mode == MODE_ENABLE_STROBE) begin
						s_nxt.en_rd = 1'b1;
					end else if (s_r.rd) begin
						s_nxt.en_rd = 1'b0;
					end else begin
						s_nxt.rw_wr = 1'b0;
					end
				end
			end
			H_STROBE: begin
				if (tdone) begin
					s_nxt.rsp   = s_r.sy2;
					s_nxt.en_rd = (s_r.mode == MODE_SEP_STROBE);
					s_nxt.rw_wr = (s_r.mode == MODE_SEP_STROBE) | s_r.rd;
					s_nxt.tmr   = HALF_CYC;
					s_nxt.st    = H_HOLD;
				end
			end
			H_START: begin
				if (tdone) begin
					s_nxt.bus_out[SCK_LINE] = 1'b0;
					s_nxt.bus_oe[SDI_LINE]  = !s_r.sh[26];
					s_nxt.tmr = HALF_CYC;
					s_nxt.st  = H_SHIFT_LO;
				end
			end
			H_SHIFT_LO: begin
				if (tdone) begin
					s_nxt.bus_out[SCK_LINE] = 1'b1;
					s_nxt.tmr = HALF_CYC;
					s_nxt.st  = H_SHIFT_HI;
				end
			end
			H_SHIFT_HI: begin
				if (tdone) begin
					if (i2c && s_r.sy2[SDI_LINE] && (s_r.bits == ACK_SLOT_A ||
						s_r.bits == ACK_SLOT_B || s_r.bits == ACK_SLOT_C)) begin
						s_nxt.nack = 1'b1;
					end
					s_nxt.sh   = {s_r.sh[25:0], 1'b0};
					s_nxt.bits = s_r.bits - 5'h01;
					s_nxt.tmr  = HALF_CYC;
					s_nxt.bus_out[SCK_LINE] = 1'b0;
					if (s_r.bits != 5'h01) begin
						s_nxt.st = H_SHIFT_LO;
						if (i2c) begin
							s_nxt.bus_oe[SDI_LINE] = !s_r.sh[25];
						end else begin
							s_nxt.bus_out[SDI_LINE] = s_r.sh[25];
						end
					end else if (i2c) begin
						s_nxt.bus_oe[SDI_LINE] = 1'b1;
						s_nxt.st = H_STOP;
					end else begin
						s_nxt.st = H_HOLD;
					end
				end
			end
			H_STOP: begin
				if (tdone) begin
					s_nxt.bus_out[SCK_LINE] = 1'b1;
					s_nxt.tmr = HALF_CYC;
					s_nxt.st  = H_STOP2;
				end
			end
			H_STOP2: begin
				if (tdone) begin
					s_nxt.bus_oe[SDI_LINE] = 1'b0;
					s_nxt.tmr = HALF_CYC;
					s_nxt.st  = H_HOLD;
				end
			end
			H_HOLD: begin
				if (tdone) begin
					s_nxt.sel_n = 1'b1;
					s_nxt.rsp_v = s_r.rd;
					s_nxt.st    = H_IDLE;
				end
			end
			default: s_nxt.st = H_IDLE;
		endcase
		if (reset_i) begin
			s_nxt       = '0;
			s_nxt.sel_n = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		s_r <= s_nxt;
	end

	assign link.iface_strap_a   = s_r.mode[1];
	assign link.iface_strap_b   = s_r.mode[0];
	assign link.power_on_init_n = s_r.por_n;
	assign link.host_sel_n      = s_r.sel_n;
	assign link.data_cmd_sel    = s_r.dc;
	assign link.en_rd           = s_r.en_rd;
	assign link.rw_wr           = s_r.rw_wr;
	assign link.host_bus_out    = s_r.bus_out;
	assign link.host_bus_oe     = s_r.bus_oe;
	assign req_ready_o          = s_r.ready;
	assign rsp_valid_o          = s_r.rsp_v;
	assign rsp_byte_o           = s_r.rsp;
	assign nack_o               = s_r.nack;

endmodule // dhi_host_end

`default_nettype wire

// ### testbench/dhi_link_chk.sv
// Concurrent checks on the pins between the host end and the display end.
`timescale 1ns/100ps
`default_nettype none

module dhi_link_chk import dhi_pkg::*; (
	// Clock and reset
	input wire logic       core_clk_i,
	input wire logic       reset_i,
	// Link pins
	input wire logic       iface_strap_a,
	input wire logic       iface_strap_b,
	input wire logic       power_on_init_n,
	input wire logic       host_sel_n,
	input wire logic       en_rd,
	input wire logic       rw_wr,
	input wire logic [7:0] host_bus_out,
	input wire logic [7:0] host_bus_oe,
	input wire logic [7:0] dev_bus_oe,
	input wire logic [7:0] host_bus_lines
);
	logic [1:0] mode;

	assign mode = {iface_strap_a, iface_strap_b};

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	// ---------------------------------------------------------------
	// Link sequences
	// ---------------------------------------------------------------
	// The bus is given five quiet cycles, since the read drive is
	// allowed to trail the rise of host_sel_n by up to four.
	sequence sel_idle_s;
		host_sel_n [*5];
	endsequence

	sequence sck_high_s;
		host_bus_lines[0] ##1 host_bus_lines[0];
	endsequence

	init_held_high_a: assert property (
		!host_sel_n |-> power_on_init_n)
		else $error("init line low during a transfer");
	serial_strobes_low_a: assert property (
		!is_parallel(mode) && !host_sel_n |-> !en_rd && !rw_wr)
		else $error("strobe pin active in a serial mode");
	enable_needs_sel_a: assert property (
		mode == MODE_ENABLE_STROBE && en_rd |-> !host_sel_n)
		else $error("enable high without host select");
	enable_width_a: assert property (
		mode == MODE_ENABLE_STROBE && $rose(en_rd) |-> en_rd [*8])
		else $error("enable pulse too short");
	enable_bus_dir_a: assert property (
		mode == MODE_ENABLE_STROBE && $rose(en_rd)
		|-> host_bus_oe == (rw_wr ? 8'h00 : 8'hff))
		else $error("host bus drive does not match direction");
	write_no_contention_a: assert property (
		mode == MODE_ENABLE_STROBE && !host_sel_n && !rw_wr
		|-> dev_bus_oe == 8'h00)
		else $error("display end drives bus during a write");
	read_strobe_sel_a: assert property (
		mode == MODE_SEP_STROBE && $fell(en_rd)
		|-> !host_sel_n && host_bus_oe == 8'h00)
		else $error("read strobe without select or bus released");
	write_strobe_sel_a: assert property (
		mode == MODE_SEP_STROBE && $fell(rw_wr)
		|-> !host_sel_n && host_bus_oe == 8'hff)
		else $error("write strobe without select or bus driven");
	deselect_quiet_a: assert property (
		is_parallel(mode) ##0 sel_idle_s |-> dev_bus_oe == 8'h00)
		else $error("display end drives bus while deselected");
	spi_line_ties_a: assert property (
		mode == MODE_SPI && !host_sel_n |-> host_bus_oe[7:3] == 5'h1f
		&& host_bus_out[7:3] == 5'h00 && !host_bus_oe[2])
		else $error("unused serial lines not tied");
	spi_data_stable_a: assert property (
		mode == MODE_SPI && !host_sel_n ##0 sck_high_s
		|-> $stable(host_bus_lines[1]))
		else $error("serial data moved while clock high");
endmodule // dhi_link_chk

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench joining the host end and the display end.
`timescale 1ns/100ps
`default_nettype none

module testbench import dhi_pkg::*;;
	logic       core_clk_i    = 1'b0;
	logic       reset_i       = 1'b1;
	logic [1:0] mode_i        = MODE_SPI;
	logic       init_req_i    = 1'b0;
	logic       req_valid_i   = 1'b0;
	logic       req_read_i    = 1'b0;
	logic       req_is_data_i = 1'b0;
	logic [7:0] req_byte_i    = 8'h00;
	logic [7:0] rd_byte_i     = 8'h00;
	logic       out_ready_i   = 1'b0;
	logic       stall         = 1'b1;
	logic       req_ready_o, rsp_valid_o, nack_o, out_valid_o;
	logic       out_is_data_o, overrun_o, init_busy_o;
	logic [7:0] rsp_byte_o, out_byte_o;
	logic [1:0] mode_o;
	logic [8:0] expq[$];
	int         seed          = 62;
	int         mismatches    = 0;
	int         n_compared    = 0;
	int         n_over        = 0;

	always #50 core_clk_i = ~core_clk_i;

	dhi_link_if link ();
	dhi_host_end dhi_host_end_inst (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .link(link.host), .mode_i(mode_i),
		.init_req_i(init_req_i), .req_valid_i(req_valid_i),
		.req_read_i(req_read_i), .req_is_data_i(req_is_data_i),
		.req_byte_i(req_byte_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o),
		.nack_o(nack_o));
	dhi_device_end dhi_device_end_inst (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .link(link.device), .rd_byte_i(rd_byte_i),
		.out_ready_i(out_ready_i), .out_valid_o(out_valid_o),
		.out_byte_o(out_byte_o), .out_is_data_o(out_is_data_o),
		.overrun_o(overrun_o), .init_busy_o(init_busy_o),
		.mode_o(mode_o));
	dhi_link_chk dhi_link_chk_inst (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .iface_strap_a(link.iface_strap_a),
		.iface_strap_b(link.iface_strap_b), .host_sel_n(link.host_sel_n),
		.power_on_init_n(link.power_on_init_n),
		.en_rd(link.en_rd), .rw_wr(link.rw_wr),
		.host_bus_out(link.host_bus_out), .host_bus_oe(link.host_bus_oe),
		.dev_bus_oe(link.dev_bus_oe),
		.host_bus_lines(link.host_bus_lines));

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// A receiver that stalls at random keeps the two-entry buffer busy.
	always @(posedge core_clk_i) begin
		out_ready_i <= stall ? 1'b0 : 1'($random(seed));
		if (overrun_o === 1'b1) n_over++;
		if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
			chk({out_is_data_o, out_byte_o},
				expq.size() > 0 ? expq.pop_front() : 9'bx);
	end

	task automatic req(input logic rd, input logic dc, input logic [7:0] b,
		output logic [7:0] rsp);
		int n;
		n = 0;
		rsp = 8'hxx;
		req_valid_i <= 1'b1;
		req_read_i <= rd;
		req_is_data_i <= dc;
		req_byte_i <= b;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 4000);
		req_valid_i <= 1'b0;
		@(posedge core_clk_i);
		do begin
			@(posedge core_clk_i);
			n++;
			if (rsp_valid_o === 1'b1) rsp = rsp_byte_o;
		end while (req_ready_o !== 1'b1 && n < 4000);
		if (n >= 4000) chk(9'h000, 9'h1ff);
	endtask

	task automatic write_one();
		logic [7:0] b;
		logic [7:0] r;
		logic       dc;
		b = 8'($random(seed));
		dc = 1'($random(seed));
		expq.push_back({dc, b});
		req(1'b0, dc, b, r);
	endtask

	initial begin
		logic [1:0] modes [4];
		logic [7:0] b;
		logic [7:0] r;
		int         n;
		modes = '{MODE_SPI, MODE_ENABLE_STROBE, MODE_SEP_STROBE, MODE_I2C};
		repeat (5) @(posedge core_clk_i);
		reset_i <= 1'b0;
		foreach (modes[i]) begin
			mode_i <= modes[i];
			init_req_i <= 1'b1;
			// The init line crosses a host flop and two sync flops
			// before busy can rise, so four edges are too few.
			repeat (6) @(posedge core_clk_i);
			chk(9'(init_busy_o), 9'h001);
			init_req_i <= 1'b0;
			n = 0;
			while (init_busy_o !== 1'b0 && n < 300) begin
				@(posedge core_clk_i);
				n++;
			end
			chk(9'(init_busy_o), 9'h000);
			chk(9'(mode_o), 9'(modes[i]));
			stall <= 1'b0;
			repeat (6) write_one();
			chk(9'(nack_o), 9'h000);
			if (is_parallel(modes[i])) begin
				repeat (3) begin
					b = 8'($random(seed));
					rd_byte_i <= b;
					req(1'b1, 1'b1, 8'h00, r);
					chk({1'b0, r}, {1'b0, b});
				end
			end
			if (modes[i] == MODE_SEP_STROBE) begin
				stall <= 1'b1;
				n = n_over;
				repeat (2) write_one();
				req(1'b0, 1'b1, 8'h5a, r);
				chk(9'(n_over - n), 9'h001);
				stall <= 1'b0;
			end
			n = 0;
			while (expq.size() > 0 && n < 3000) begin
				@(posedge core_clk_i);
				n++;
			end
			chk(9'(expq.size()), 9'h000);
		end
		end_sim();
	end

	initial begin
		#(60000 * CLK_NS);
		mismatches++;
		end_sim();
	end
endmodule // testbench

`default_nettype wire
